// ### design/ccfd_top.sv
// Clock controller with source selection, gating, power-down and divider output.
`timescale 1ns/1ps
module ccfd_top
    import ccfd_pkg::*;
#(
    parameter int NUM_PERIPH = 4
) (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic [CCFD_ADDR_W-1:0] i_address,
    input wire logic i_read,
    input wire logic i_write,
    input wire logic [CCFD_DATA_W-1:0] i_writedata,
    input wire logic [3:0] i_byteenable,
    output logic [CCFD_DATA_W-1:0] o_readdata,
    output logic o_waitrequest,
    input wire logic i_src_xtal,
    input wire logic i_src_hirc,
    input wire logic i_src_pll,
    input wire logic i_src_lirc,
    input wire logic i_wfi,
    input wire logic i_wake,
    output logic o_xtal_en,
    output logic o_hirc_en,
    output logic o_lirc_en,
    output logic o_pll_en,
    output logic o_pll_ref_sel,
    output logic o_sys_clk,
    output logic o_tick_clk,
    output logic [NUM_PERIPH-1:0] o_periph_clk,
    output logic o_freq_out,
    output logic o_sleeping
);
    localparam int PSEL_W = 2 * NUM_PERIPH;

    // Bus and register state
    logic wait_q;
    logic [CCFD_DATA_W-1:0] rdata_q;
    logic [7:0] pwr_q;
    logic [2:0] sys_sel_q;
    logic [2:0] tick_sel_q;
    logic tick_ext_q;
    logic [NUM_PERIPH-1:0] pgate_q;
    logic [PSEL_W-1:0] psel_q;
    logic [CCFD_DIV_SEL_W-1:0] div_sel_q;
    logic div_en_q;
    // Block state
    ccfd_pwr_e pwr_state_q, pwr_state_d;
    ccfd_sw_e sw_state_q, sw_state_d;
    logic [1:0] act_idx_q, act_idx_d;
    logic [1:0] pend_idx_q, pend_idx_d;
    logic sys_gate_q, sys_gate_d;
    logic [CCFD_DIV_STAGES-1:0] div_cnt_q, div_cnt_d;
    logic div_run_q, div_run_d;

    // Bus decode
    wire req = i_read | i_write;
    wire take = req & wait_q;
    wire wr_fire = i_write & ~wait_q & i_byteenable[0];
    wire wr_pwr = wr_fire & (i_address == CCFD_OFF_PWRCTL);
    wire wr_sel0 = wr_fire & (i_address == CCFD_OFF_CLOCK_SELECT_REGISTER_ZERO);
    wire wr_tick = wr_fire & (i_address == CCFD_OFF_TICKCSR);
    wire wr_pgate = wr_fire & (i_address == CCFD_OFF_PGATE);
    wire wr_psel = wr_fire & (i_address == CCFD_OFF_PSEL);
    wire wr_div = wr_fire & (i_address == CCFD_OFF_DIVCTL);

    // Source vector, indexed by source code
    wire [CCFD_NSRC-1:0] src_vec = {i_src_hirc, i_src_lirc, i_src_pll, i_src_xtal};
    wire in_run = (pwr_state_q == CCFD_PWR_RUN);
    wire sleep_en = pwr_q[CCFD_PWR_SLEEP];
    wire lirc_on = pwr_q[CCFD_PWR_LIRC];

    // Power state machine
    wire enter_down = sleep_en & i_wfi;
    always_comb begin
        case (pwr_state_q)
            CCFD_PWR_RUN: pwr_state_d = enter_down ? CCFD_PWR_DOWN : CCFD_PWR_RUN;
            CCFD_PWR_DOWN: pwr_state_d = i_wake ? CCFD_PWR_WAKE : CCFD_PWR_DOWN;
            CCFD_PWR_WAKE: pwr_state_d = CCFD_PWR_RUN;
            default: pwr_state_d = CCFD_PWR_RUN;
        endcase
    end
    wire run_d = (pwr_state_d == CCFD_PWR_RUN);
    wire down_d = (pwr_state_d != CCFD_PWR_RUN);

    // Glitch-free system clock switch
    wire [1:0] req_idx = ccfd_sel_idx(sys_sel_q);
    always_comb begin
        sw_state_d = sw_state_q;
        act_idx_d = act_idx_q;
        pend_idx_d = pend_idx_q;
        sys_gate_d = sys_gate_q;
        case (sw_state_q)
            CCFD_SW_IDLE: begin
                if (req_idx != act_idx_q) begin
                    pend_idx_d = req_idx;
                    sw_state_d = CCFD_SW_OFF;
                end
            end
            CCFD_SW_OFF: begin
                if (!src_vec[act_idx_q]) begin
                    sys_gate_d = 1'b0;
                    sw_state_d = CCFD_SW_ON;
                end
            end
            CCFD_SW_ON: begin
                if (!src_vec[pend_idx_q]) begin
                    act_idx_d = pend_idx_q;
                    sys_gate_d = 1'b1;
                    sw_state_d = CCFD_SW_IDLE;
                end
            end
            default: sw_state_d = CCFD_SW_IDLE;
        endcase
    end
    wire sys_clk_d = sys_gate_d & run_d & src_vec[act_idx_d];
    wire [1:0] tick_idx = ccfd_sel_idx(tick_sel_q);
    wire tick_clk_d = run_d & (tick_ext_q ? src_vec[tick_idx] : sys_clk_d);

    // Per-peripheral gating and source selection
    logic [NUM_PERIPH-1:0] pclk_d;
    for (genvar gi = 0; gi < NUM_PERIPH; gi++) begin : g_periph
        wire [1:0] p_idx = psel_q[2*gi +: 2];
        wire p_lirc = (p_idx == CCFD_SRC_LIRC);
        wire p_allow = run_d | (p_lirc & lirc_on);
        assign pclk_d[gi] = pgate_q[gi] & p_allow & src_vec[p_idx];
    end

    // Frequency divider
    wire div_out_d = div_cnt_d[div_sel_q];
    always_comb begin
        div_run_d = div_run_q;
        if (div_en_q) begin
            div_run_d = 1'b1;
        end else if (!div_cnt_q[div_sel_q]) begin
            div_run_d = 1'b0;
        end
        div_cnt_d = div_run_d ? div_cnt_q + 1'b1 : div_cnt_q;
    end

    // Read mux
    logic [CCFD_DATA_W-1:0] rmux;
    always_comb begin
        rmux = '0;
        case (i_address)
            CCFD_OFF_PWRCTL: rmux[7:0] = pwr_q;
            CCFD_OFF_CLOCK_SELECT_REGISTER_ZERO: rmux[5:0] = {tick_sel_q, sys_sel_q};
            CCFD_OFF_TICKCSR: rmux[CCFD_TICK_SRC] = tick_ext_q;
            CCFD_OFF_PGATE: rmux[NUM_PERIPH-1:0] = pgate_q;
            CCFD_OFF_PSEL: rmux[PSEL_W-1:0] = psel_q;
            CCFD_OFF_DIVCTL: rmux[4:0] = {div_en_q, div_sel_q};
            CCFD_OFF_STATUS: rmux[6:0] = {div_run_q, act_idx_q, sw_state_q != CCFD_SW_IDLE, 1'b0, pwr_state_q};
            default: rmux = '0;
        endcase
    end

    // Bus slave handshake
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            wait_q <= 1'b1;
            rdata_q <= '0;
        end else begin
            wait_q <= ~take;
            if (take && i_read) begin
                rdata_q <= rmux;
            end
        end
    end

    // Software registers
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            pwr_q <= CCFD_PWR_RST;
            sys_sel_q <= CCFD_SYS_RST;
            tick_sel_q <= CCFD_TICK_RST;
            tick_ext_q <= 1'b0;
            pgate_q <= '0;
            psel_q <= '0;
            div_sel_q <= '0;
            div_en_q <= 1'b0;
        end else begin
            if (wr_pwr) pwr_q <= i_writedata[7:0];
            if (wr_sel0) sys_sel_q <= i_writedata[CCFD_SYS_LSB +: CCFD_SEL_W];
            if (wr_sel0) tick_sel_q <= i_writedata[CCFD_TICK_LSB +: CCFD_SEL_W];
            if (wr_tick) tick_ext_q <= i_writedata[CCFD_TICK_SRC];
            if (wr_pgate) pgate_q <= i_writedata[NUM_PERIPH-1:0];
            if (wr_psel) psel_q <= i_writedata[PSEL_W-1:0];
            if (wr_div) div_sel_q <= i_writedata[CCFD_DIV_SEL_LSB +: CCFD_DIV_SEL_W];
            if (wr_div) div_en_q <= i_writedata[CCFD_DIV_EN];
        end
    end

    // Block state
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            pwr_state_q <= CCFD_PWR_RUN;
            sw_state_q <= CCFD_SW_IDLE;
            act_idx_q <= CCFD_SRC_HIRC;
            pend_idx_q <= CCFD_SRC_HIRC;
            sys_gate_q <= 1'b1;
            div_cnt_q <= '0;
            div_run_q <= 1'b0;
        end else begin
            pwr_state_q <= pwr_state_d;
            sw_state_q <= sw_state_d;
            act_idx_q <= act_idx_d;
            pend_idx_q <= pend_idx_d;
            sys_gate_q <= sys_gate_d;
            div_cnt_q <= div_cnt_d;
            div_run_q <= div_run_d;
        end
    end

    // Registered outputs
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_xtal_en <= 1'b0;
            o_hirc_en <= 1'b1;
            o_lirc_en <= 1'b1;
            o_pll_en <= 1'b0;
            o_pll_ref_sel <= 1'b0;
            o_sys_clk <= 1'b0;
            o_tick_clk <= 1'b0;
            o_periph_clk <= '0;
            o_freq_out <= 1'b0;
            o_sleeping <= 1'b0;
        end else begin
            o_xtal_en <= pwr_q[CCFD_PWR_XTAL] & run_d;
            o_hirc_en <= pwr_q[CCFD_PWR_HIRC] & run_d;
            o_lirc_en <= lirc_on;
            o_pll_en <= pwr_q[CCFD_PWR_PLL] & run_d;
            o_pll_ref_sel <= pwr_q[CCFD_PWR_PLLREF];
            o_sys_clk <= sys_clk_d;
            o_tick_clk <= tick_clk_d;
            o_periph_clk <= pclk_d;
            o_freq_out <= div_out_d & div_run_d;
            o_sleeping <= down_d;
        end
    end

    // Checks
    sequence s_down_req;
        in_run && enter_down;
    endsequence
    sequence s_wake_path;
        (pwr_state_q == CCFD_PWR_WAKE) ##1 (pwr_state_q == CCFD_PWR_RUN);
    endsequence

    no_lone_entry_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        in_run && !enter_down |=> pwr_state_q == CCFD_PWR_RUN)
        else $error("power-down entered without both conditions");
    sleep_entry_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        s_down_req |=> pwr_state_q == CCFD_PWR_DOWN ##0 o_sleeping)
        else $error("power-down not entered");
    osc_off_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        pwr_state_q == CCFD_PWR_DOWN |-> !o_xtal_en && !o_hirc_en && !o_pll_en)
        else $error("oscillator enabled in power-down");
    wake_leave_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (pwr_state_q == CCFD_PWR_DOWN) && i_wake |=> s_wake_path)
        else $error("wake-up did not leave power-down");
    down_hold_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (pwr_state_q == CCFD_PWR_DOWN) && !i_wake |=> pwr_state_q == CCFD_PWR_DOWN)
        else $error("power-down left without wake-up");
    clocks_stop_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        pwr_state_q == CCFD_PWR_DOWN |-> !o_sys_clk && !o_tick_clk)
        else $error("system clock running in power-down");
    lirc_keep_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        lirc_on && !wr_pwr |=> o_lirc_en)
        else $error("low-frequency oscillator stopped");
    div_count_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        div_run_q && $past(div_run_q) |-> div_cnt_q == $past(div_cnt_q) + 1'b1)
        else $error("divider counter skipped");
    div_start_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        div_en_q |=> div_run_q)
        else $error("divider did not start");
    div_stop_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        !div_en_q && !div_run_q |-> !o_freq_out)
        else $error("divider output not held low");
    switch_quiet_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        sw_state_q == CCFD_SW_ON |-> !o_sys_clk)
        else $error("system clock pulse during switch");
    bus_answer_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        req && o_waitrequest |=> !o_waitrequest)
        else $error("bus answer late");

    assign o_readdata = rdata_q;
    assign o_waitrequest = wait_q;
endmodule : ccfd_top

// ### shared/ccfd_pkg.sv
// Constants and helpers for the clock controller with frequency divider.
package ccfd_pkg;
    localparam int CCFD_ADDR_W = 5;
    localparam int CCFD_DATA_W = 32;
    // Register byte offsets
    localparam logic [4:0] CCFD_OFF_PWRCTL = 5'h00;
    localparam logic [4:0] CCFD_OFF_CLOCK_SELECT_REGISTER_ZERO = 5'h04;
    localparam logic [4:0] CCFD_OFF_TICKCSR = 5'h08;
    localparam logic [4:0] CCFD_OFF_PGATE = 5'h0C;
    localparam logic [4:0] CCFD_OFF_PSEL = 5'h10;
    localparam logic [4:0] CCFD_OFF_DIVCTL = 5'h14;
    localparam logic [4:0] CCFD_OFF_STATUS = 5'h18;
    // Power control fields
    localparam int CCFD_PWR_XTAL = 0;
    localparam int CCFD_PWR_HIRC = 1;
    localparam int CCFD_PWR_LIRC = 2;
    localparam int CCFD_PWR_PLL = 3;
    localparam int CCFD_PWR_PLLREF = 4;
    localparam int CCFD_PWR_SLEEP = 7;
    localparam logic [7:0] CCFD_PWR_RST = 8'h06;
    // Clock select zero fields
    localparam int CCFD_SYS_LSB = 0;
    localparam int CCFD_TICK_LSB = 3;
    localparam int CCFD_SEL_W = 3;
    localparam logic [2:0] CCFD_SYS_RST = 3'h7;
    localparam logic [2:0] CCFD_TICK_RST = 3'h0;
    // Tick control field
    localparam int CCFD_TICK_SRC = 2;
    // Divider control fields
    localparam int CCFD_DIV_SEL_LSB = 0;
    localparam int CCFD_DIV_SEL_W = 4;
    localparam int CCFD_DIV_EN = 4;
    localparam int CCFD_DIV_STAGES = 16;
    // Source indices into the source vector
    localparam logic [1:0] CCFD_SRC_XTAL = 2'h0;
    localparam logic [1:0] CCFD_SRC_PLL = 2'h1;
    localparam logic [1:0] CCFD_SRC_LIRC = 2'h2;
    localparam logic [1:0] CCFD_SRC_HIRC = 2'h3;
    localparam int CCFD_NSRC = 4;

    typedef enum logic [1:0] {
        CCFD_PWR_RUN = 2'b00,
        CCFD_PWR_DOWN = 2'b01,
        CCFD_PWR_WAKE = 2'b11
    } ccfd_pwr_e;

    typedef enum logic [1:0] {
        CCFD_SW_IDLE = 2'b00,
        CCFD_SW_OFF = 2'b01,
        CCFD_SW_ON = 2'b11
    } ccfd_sw_e;

    // Select code to source index; codes 3..7 pick the RC oscillator
    function automatic logic [1:0] ccfd_sel_idx(input logic [2:0] sel);
        case (sel)
            3'h0: ccfd_sel_idx = CCFD_SRC_XTAL;
            3'h1: ccfd_sel_idx = CCFD_SRC_PLL;
            3'h2: ccfd_sel_idx = CCFD_SRC_LIRC;
            default: ccfd_sel_idx = CCFD_SRC_HIRC;
        endcase
    endfunction : ccfd_sel_idx
endpackage : ccfd_pkg

// ### tb/ccfd_osc_model.sv
// Oscillator model: source clocks that toggle only while enabled.
`timescale 1ns/1ps
module ccfd_osc_model (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic [3:0] i_en,
    output logic [3:0] o_src
);
    localparam int HALF [4] = '{1, 2, 5, 3};
    logic [3:0] cnt_q [4];
    // Crystal, PLL, low-freq and RC sources
    always_ff @(posedge i_clk_sys) begin
        for (int k = 0; k < 4; k++) begin
            if (i_rst || !i_en[k]) begin // Stopped source sits low
                cnt_q[k] <= 4'h0;
                o_src[k] <= 1'b0;
            end else if (cnt_q[k] == 4'(HALF[k] - 1)) begin
                cnt_q[k] <= 4'h0;
                o_src[k] <= !o_src[k];
            end else begin
                cnt_q[k] <= cnt_q[k] + 4'h1;
            end
        end
    end
endmodule : ccfd_osc_model

// ### tb/tb_top.sv
// Self-checking bench for the clock controller.
`timescale 1ns/1ps
module tb_top;
    import ccfd_pkg::*;
    typedef struct {logic [4:0] a; logic [31:0] d; logic [31:0] r;} ccfd_row_s;
    logic i_clk_sys = 1'b0;
    logic i_rst = 1'b1;
    logic [4:0] i_address = 5'h00;
    logic i_read = 1'b0;
    logic i_write = 1'b0;
    logic [31:0] i_writedata = 32'h0;
    logic [3:0] i_byteenable = 4'hF;
    logic i_wfi = 1'b0;
    logic i_wake = 1'b0;
    logic [31:0] o_readdata, q;
    logic o_waitrequest, o_xtal_en, o_hirc_en, o_lirc_en, o_pll_en, o_pll_ref_sel;
    logic o_sys_clk, o_tick_clk, o_freq_out, o_sleeping;
    logic [3:0] o_periph_clk, s;
    int bad_count = 0;
    int tests_run = 0;
    int exp_sys, exp_tick, c;
    int exp_per [4];
    int nl [3] = '{0, 3, 6};
    ccfd_row_s rows [7] = '{'{CCFD_OFF_PWRCTL, 32'h1F, 32'h1F}, '{CCFD_OFF_CLOCK_SELECT_REGISTER_ZERO, 32'h3F, 32'h3F},
        '{CCFD_OFF_TICKCSR, 32'h04, 32'h04}, '{CCFD_OFF_PGATE, 32'h0F, 32'h0F},
        '{CCFD_OFF_PSEL, 32'hE4, 32'hE4}, '{CCFD_OFF_DIVCTL, 32'h05, 32'h05}, '{5'h1C, 32'hFF, 32'h00}};
    always #25 i_clk_sys = ~i_clk_sys;
    ccfd_top ccfd_top_inst (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_address(i_address), .i_read(i_read),
        .i_write(i_write), .i_writedata(i_writedata), .i_byteenable(i_byteenable), .o_readdata(o_readdata),
        .o_waitrequest(o_waitrequest), .i_src_xtal(s[0]), .i_src_hirc(s[3]), .i_src_pll(s[1]),
        .i_src_lirc(s[2]), .i_wfi(i_wfi), .i_wake(i_wake), .o_xtal_en(o_xtal_en), .o_hirc_en(o_hirc_en),
        .o_lirc_en(o_lirc_en), .o_pll_en(o_pll_en), .o_pll_ref_sel(o_pll_ref_sel), .o_sys_clk(o_sys_clk),
        .o_tick_clk(o_tick_clk), .o_periph_clk(o_periph_clk), .o_freq_out(o_freq_out),
        .o_sleeping(o_sleeping));
    ccfd_osc_model ccfd_osc_model_inst (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
        .i_en({o_hirc_en, o_lirc_en, o_pll_en, o_xtal_en}), .o_src(s));
    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : give_verdict
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_clk_sys);
        i_address <= a;
        i_write <= w;
        i_read <= !w;
        i_writedata <= d;
        do begin
            @(posedge i_clk_sys);
            n++;
        end while (o_waitrequest !== 1'b0 && n < 50);
        if (o_waitrequest !== 1'b0) begin
            bad_count++;
            give_verdict();
        end
        q = o_readdata;
        i_read <= 1'b0;
        i_write <= 1'b0;
    endtask : bus
    task automatic rchk(input string nm, input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(nm, q & m, e);
    endtask : rchk
    function automatic logic ev(input logic [3:0] p, input int i);
        return (i < 0) ? 1'b0 : p[i];
    endfunction : ev
    function automatic int mp(input int k);
        return (k > 2) ? 3 : k;
    endfunction : mp
    task automatic watch(input int n);
        logic [3:0] p;
        @(negedge i_clk_sys);
        p = s;
        repeat (n) begin
            @(negedge i_clk_sys);
            chk("sys", o_sys_clk, ev(p, exp_sys));
            chk("tick", o_tick_clk, ev(p, exp_tick));
            for (int k = 0; k < 4; k++) chk("per", o_periph_clk[k], ev(p, exp_per[k]));
            p = s;
        end
    endtask : watch
    task automatic pulse(input logic wk);
        @(posedge i_clk_sys);
        i_wake <= wk;
        i_wfi <= !wk;
        @(posedge i_clk_sys);
        i_wake <= 1'b0;
        i_wfi <= 1'b0;
    endtask : pulse
    task automatic rise(output int n);
        logic pv;
        n = 0;
        pv = o_freq_out;
        forever begin
            @(negedge i_clk_sys);
            n++;
            if (pv === 1'b0 && o_freq_out === 1'b1) break;
            pv = o_freq_out;
            if (n > 300) begin
                bad_count++;
                give_verdict();
            end
        end
    endtask : rise
    initial begin
        repeat (7) @(posedge i_clk_sys);
        @(negedge i_clk_sys);
        chk("wait", o_waitrequest, 1'b1);
        @(posedge i_clk_sys);
        i_rst <= 1'b0;
        @(negedge i_clk_sys);
        chk("rst", {o_xtal_en, o_hirc_en, o_lirc_en, o_pll_en, o_sleeping, o_freq_out}, 6'h18);
        rchk("pwr", CCFD_OFF_PWRCTL, 32'hFF, 32'h06);
        rchk("sel", CCFD_OFF_CLOCK_SELECT_REGISTER_ZERO, 32'h3F, 32'h07);
        foreach (rows[j]) begin
            bus(1'b1, rows[j].a, rows[j].d);
            rchk("reg", rows[j].a, 32'hFFFFFFFF, rows[j].r);
        end
        @(posedge i_clk_sys);
        i_byteenable <= 4'h0;
        bus(1'b1, CCFD_OFF_PWRCTL, 32'h00);
        i_byteenable <= 4'hF;
        rchk("lane", CCFD_OFF_PWRCTL, 32'hFF, 32'h1F);
        chk("osc", {o_xtal_en, o_hirc_en, o_lirc_en, o_pll_en, o_pll_ref_sel}, 5'h1F);
        for (int k = 0; k < 4; k++) exp_per[k] = k;
        for (int k = 0; k < 8; k++) begin
            bus(1'b1, CCFD_OFF_CLOCK_SELECT_REGISTER_ZERO, 32'(k + ((7 - k) << 3)));
            exp_sys = mp(k);
            exp_tick = mp(7 - k);
            repeat (40) @(posedge i_clk_sys);
            watch(12);
        end
        bus(1'b1, CCFD_OFF_TICKCSR, 32'h0);
        exp_tick = exp_sys;
        watch(12);
        bus(1'b1, CCFD_OFF_PGATE, 32'h5);
        bus(1'b1, CCFD_OFF_PSEL, 32'h2);
        exp_per = '{2, -1, 0, -1};
        bus(1'b1, CCFD_OFF_CLOCK_SELECT_REGISTER_ZERO, 32'h0);
        exp_sys = 0;
        exp_tick = 0;
        repeat (40) @(posedge i_clk_sys);
        watch(12);
        pulse(1'b0);
        pulse(1'b1);
        bus(1'b1, CCFD_OFF_PWRCTL, 32'h9F);
        repeat (5) @(posedge i_clk_sys);
        chk("alone", o_sleeping, 1'b0);
        pulse(1'b0);
        @(negedge i_clk_sys);
        chk("down", {o_sleeping, o_xtal_en, o_hirc_en, o_pll_en, o_lirc_en}, 5'h11);
        exp_sys = -1;
        exp_tick = -1;
        exp_per[2] = -1;
        watch(30);
        rchk("state", CCFD_OFF_STATUS, 32'h3, 32'h1);
        pulse(1'b1);
        @(negedge i_clk_sys);
        chk("wake", o_sleeping, 1'b1);
        @(negedge i_clk_sys);
        chk("run", {o_sleeping, o_xtal_en, o_hirc_en}, 3'h3);
        rchk("keep", CCFD_OFF_PWRCTL, 32'hFF, 32'h9F);
        bus(1'b1, CCFD_OFF_PWRCTL, 32'h1B);
        repeat (2) @(negedge i_clk_sys);
        chk("lirc", o_lirc_en, 1'b0);
        foreach (nl[j]) begin
            bus(1'b1, CCFD_OFF_DIVCTL, 32'h10 | nl[j]);
            rise(c);
            rise(c);
            chk("period", c, 1 << (nl[j] + 1));
            bus(1'b1, CCFD_OFF_DIVCTL, nl[j]);
            c = 0;
            while (o_freq_out !== 1'b0 && c < 200) begin
                @(negedge i_clk_sys);
                c++;
            end
            chk("stop", c <= (1 << nl[j]) + 4, 1'b1);
            repeat (1 << (nl[j] + 2)) begin
                @(negedge i_clk_sys);
                chk("held", o_freq_out, 1'b0);
            end
        end
        @(posedge i_clk_sys);
        i_rst <= 1'b1;
        repeat (2) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        @(negedge i_clk_sys);
        chk("rst2", {o_xtal_en, o_hirc_en, o_lirc_en, o_pll_en, o_pll_ref_sel, o_sleeping, o_freq_out}, 7'h30);
        rchk("pwr2", CCFD_OFF_PWRCTL, 32'hFF, 32'h06);
        give_verdict();
    end
endmodule : tb_top
